// file: rtl/dbf_pkg.sv
// Package for the stream data bus field access block.
// Assumes one data clock; the shared constants and all bus types live here.
package dbf_pkg;
   // Sample width and parallel samples, two-channel base design.
   localparam int SAMP_W = 16;
   localparam int PAR = 16;
   localparam int NCH = 2; // ADC channels, indexed from zero.
   localparam int LR_PAR = 8; // lowrate_parallel_count.
   localparam int NLR = 2; // Low-rate channels on the reduced bus.
   localparam int BUS_PIPELINE = 4; // Pass-through depth.
   // Timestamp step per data clock cycle.
   localparam logic [63:0] TS_STEP = 64'h80;
   localparam logic [63:0] TS_RESET = 64'h0;
   // Register byte offsets.
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_LOAD_LO = 8'h04;
   localparam logic [7:0] ADR_LOAD_HI = 8'h08;
   localparam logic [7:0] ADR_STATUS = 8'h0c;
   localparam logic [7:0] ADR_TS_LO = 8'h10;
   localparam logic [7:0] ADR_TS_HI = 8'h14;
   localparam logic [7:0] ADR_HDR_LO = 8'h18;
   localparam logic [7:0] ADR_HDR_HI = 8'h1c;
   // Field positions inside the registers.
   localparam int CTRL_INH_BIT = 0;
   localparam int CTRL_ARM_BIT = 1;
   localparam int STAT_WAIT_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0;
   // Insert-enable bit positions per field.
   localparam int INS_TS = 0;
   localparam int INS_INH = 1;
   localparam int INS_SYNC = 2;
   localparam int INS_DATA = 3;
   localparam int INS_VALID = 4;
   typedef logic [PAR*SAMP_W-1:0] dbf_data_t;
   typedef logic [LR_PAR*SAMP_W-1:0] dbf_lr_t;
   typedef logic [4:0] dbf_ins_t;
   // Real-time bus: shared metadata, per-channel data.
   typedef struct packed {
      logic [63:0] ts;
      logic inhibit;
      logic sync;
      dbf_data_t [NCH-1:0] data;
   } dbf_rt_s;
   // One ADC channel on the reduced-rate bus.
   typedef struct packed {
      logic [63:0] ts;
      logic inhibit;
      logic sync;
      logic valid;
      dbf_data_t data;
   } dbf_rr_ch_s;
   // One low-rate channel.
   typedef struct packed {
      logic valid;
      dbf_lr_t data;
   } dbf_rr_lr_s;
   typedef struct packed {
      dbf_rr_ch_s [NCH-1:0] ch;
      dbf_rr_lr_s [NLR-1:0] lr;
   } dbf_rr_s;
endpackage : dbf_pkg

// file: rtl/dbf_pipe.sv
// Fixed-depth delay line for whole bus words.
// Assumes the caller flattens its bus struct to W bits.
`timescale 1ns/1ns
`default_nettype none
module dbf_pipe #(
   parameter int W = 8,
   parameter int D = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] stg_r [D]; // Delay stages, index 0 newest.
   logic [W-1:0] stg_nxt [D];
   logic [7:0] fill_r; // Cycles since reset, held at the depth D; for checking only.

   // Shift one stage per cycle.
   always_comb begin
      stg_nxt[0] = d;
      for (int i = 1; i < D; i++) begin
         stg_nxt[i] = stg_r[i-1];
      end
   end

   // Register the stages; reset clears them so no stale word leaks.
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < D; i++) begin
            stg_r[i] <= '0;
         end
      end else begin
         stg_r <= stg_nxt;
      end
   end

   assign q = stg_r[D-1];

   // Counts up to the depth once reset ends.
   always_ff @(posedge clk) begin
      if (rst) begin
         fill_r <= 8'h00;
      end else if (fill_r != 8'(D)) begin
         fill_r <= fill_r + 8'h01;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   pass_delay_a: assert property (
      fill_r == 8'(D) |-> q == $past(d, D))
      else $error("pass-through word not delayed by depth");
endmodule : dbf_pipe
`default_nettype wire

// file: rtl/dbf_tstamp.sv
// Timestamp counter with its synchronization mechanism.
// Assumes arm and sync event are single-cycle data clock pulses.
`timescale 1ns/1ns
`default_nettype none
module dbf_tstamp
   import dbf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic arm,
   input wire logic sync_evt,
   input wire logic [63:0] load_val,
   output logic [63:0] ts,
   output logic waiting,
   output logic done
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_WAIT = 3'b010,
      S_DONE = 3'b100
   } dbf_sync_e;
   dbf_sync_e st_r, st_nxt; // Sync mechanism state.
   logic [63:0] ts_r, ts_nxt; // Time base counter.
   logic load; // Realign this cycle.

   // Arming wins over a coincident event so no arm is lost.
   always_comb begin
      st_nxt = st_r;
      load = 1'b0;
      case (st_r)
         S_IDLE: begin
            if (arm) st_nxt = S_WAIT;
         end
         S_WAIT: begin
            if (sync_evt && !arm) begin
               st_nxt = S_DONE;
               load = 1'b1;
            end
         end
         S_DONE: begin
            if (arm) st_nxt = S_WAIT;
         end
         default: st_nxt = S_IDLE;
      endcase
      ts_nxt = load ? load_val : ts_r + TS_STEP;
   end

   // Register state and counter.
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= S_IDLE;
         ts_r <= TS_RESET;
      end else begin
         st_r <= st_nxt;
         ts_r <= ts_nxt;
      end
   end

   assign ts = ts_r;
   assign waiting = (st_r == S_WAIT);
   assign done = (st_r == S_DONE);

   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ts_step_a: assert property (
      !load |=> ts == $past(ts) + 64'h80)
      else $error("timestamp did not step by 128");
   ts_mono_a: assert property (
      !load ##1 !load |=> ts > $past(ts, 2))
      else $error("timestamp not increasing");
   sync_high_a: assert property (
      arm |=> waiting [*2] or (waiting ##1 done))
      else $error("sync field not high after arming");
   sync_low_a: assert property (
      waiting && sync_evt && !arm |=> !waiting && done
         && ts == $past(load_val))
      else $error("sync did not complete on event");
   never_arm_a: assert property (
      !waiting && !done && !arm |=> !waiting && !done)
      else $error("sync field high without arming");
   sync_done_c: cover property (waiting ##1 done);
endmodule : dbf_tstamp
`default_nettype wire

// file: rtl/dbf_top.sv
// Data bus field access: builds the real-time bus, serves two user
// areas with extraction and insertion, and redefines the bus.
// Assumes user logic answers with the pipeline depth as latency.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module dbf_top
   import dbf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wr_data,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rd_data,
   // Acquisition side.
   input wire dbf_data_t [NCH-1:0] adc_data,
   input wire logic sync_evt,
   input wire logic trig_in,
   // First user area, real-time layout.
   output dbf_rt_s ul1_ext,
   input wire dbf_rt_s ul1_ins,
   input wire dbf_ins_t ul1_ins_en,
   // Second user area, reduced-rate layout.
   output dbf_rr_s ul2_ext,
   input wire dbf_rr_s ul2_ins,
   input wire dbf_ins_t [NCH-1:0] ul2_ins_en,
   input wire logic [NLR-1:0] ul2_lr_en,
   // Bus towards the packet stage, and record header timestamp.
   output dbf_rr_s bus_out,
   output logic [63:0] hdr_ts,
   output logic hdr_valid
);
   localparam int RT_W = $bits(dbf_rt_s);
   localparam int RR_W = $bits(dbf_rr_s);

   logic [31:0] ctrl_r, ctrl_nxt; // Inhibit control.
   logic [63:0] load_r, load_nxt; // Value taken on sync.
   logic [31:0] rd_r, rd_nxt; // Read data, one cycle after strobe.
   logic arm; // Write pulse that arms the sync mechanism.
   logic [63:0] ts; // Live time base.
   logic waiting, done; // Sync mechanism status.
   dbf_rt_s rt_src, rt_dly, rt_mrg; // Real-time bus stages.
   dbf_rr_s rr_src, rr_dly, rr_mrg; // Reduced-rate bus stages.
   dbf_rt_s ul1_r; // Registered extraction, first area.
   dbf_rr_s ul2_r, out_r, out_nxt; // Second area and output.
   logic [63:0] hdr_r, hdr_nxt; // Header timestamp.
   logic hv_r, hv_nxt; // Header strobe.
   logic acc; // Trigger accepted into a record this cycle.

   // Picks one reduced-rate channel, inserted or passed through.
   function automatic dbf_rr_ch_s ch_merge(dbf_rr_ch_s dly,
         dbf_rr_ch_s ins, dbf_ins_t en);
      dbf_rr_ch_s r;
      r = dly;
      if (en[INS_TS]) r.ts = ins.ts;
      if (en[INS_INH]) r.inhibit = ins.inhibit;
      if (en[INS_SYNC]) r.sync = ins.sync;
      if (en[INS_DATA]) r.data = ins.data;
      if (en[INS_VALID]) r.valid = ins.valid;
      return r;
   endfunction : ch_merge

   // Register writes; the arm bit only pulses and is never stored.
   always_comb begin
      ctrl_nxt = ctrl_r;
      load_nxt = load_r;
      arm = 1'b0;
      if (reg_wr) begin
         case (reg_addr)
            ADR_CTRL: begin
               ctrl_nxt = '0;
               ctrl_nxt[CTRL_INH_BIT] = reg_wr_data[CTRL_INH_BIT];
               arm = reg_wr_data[CTRL_ARM_BIT];
            end
            ADR_LOAD_LO: load_nxt[31:0] = reg_wr_data;
            ADR_LOAD_HI: load_nxt[63:32] = reg_wr_data;
            default: ; // Read-only or unmapped: write ignored.
         endcase
      end
   end

   // Read mux; unmapped addresses read zero.
   always_comb begin
      rd_nxt = '0;
      if (reg_rd) begin
         case (reg_addr)
            ADR_CTRL: rd_nxt = ctrl_r;
            ADR_LOAD_LO: rd_nxt = load_r[31:0];
            ADR_LOAD_HI: rd_nxt = load_r[63:32];
            ADR_STATUS: begin
               rd_nxt[STAT_WAIT_BIT] = waiting;
               rd_nxt[STAT_DONE_BIT] = done;
            end
            ADR_TS_LO: rd_nxt = ts[31:0];
            ADR_TS_HI: rd_nxt = ts[63:32];
            ADR_HDR_LO: rd_nxt = hdr_r[31:0];
            ADR_HDR_HI: rd_nxt = hdr_r[63:32];
            default: rd_nxt = '0;
         endcase
      end
   end

   // Register file state.
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r <= CTRL_RESET;
         load_r <= TS_RESET;
         rd_r <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         load_r <= load_nxt;
         rd_r <= rd_nxt;
      end
   end

   dbf_tstamp u_ts (
      .clk(clk),
      .rst(rst),
      .arm(arm),
      .sync_evt(sync_evt),
      .load_val(load_r),
      .ts(ts),
      .waiting(waiting),
      .done(done)
   );

   // Shared fields appear once on the real-time bus.
   always_comb begin
      rt_src.ts = ts;
      rt_src.inhibit = ctrl_r[CTRL_INH_BIT];
      rt_src.sync = waiting;
      rt_src.data = adc_data;
   end

   dbf_pipe #(.W(RT_W), .D(BUS_PIPELINE)) u_pipe1 (
      .clk(clk),
      .rst(rst),
      .d(ul1_r),
      .q(rt_dly)
   );

   // First area insertion; fields not enabled come from the delay.
   always_comb begin
      rt_mrg = rt_dly;
      if (ul1_ins_en[INS_TS]) rt_mrg.ts = ul1_ins.ts;
      if (ul1_ins_en[INS_INH]) rt_mrg.inhibit = ul1_ins.inhibit;
      if (ul1_ins_en[INS_SYNC]) rt_mrg.sync = ul1_ins.sync;
      if (ul1_ins_en[INS_DATA]) rt_mrg.data = ul1_ins.data;
   end

   // Redefinition point: shared fields copied to every channel,
   // every cycle valid, low-rate channels start empty.
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         rr_src.ch[c].ts = rt_mrg.ts;
         rr_src.ch[c].inhibit = rt_mrg.inhibit;
         rr_src.ch[c].sync = rt_mrg.sync;
         rr_src.ch[c].valid = 1'b1;
         rr_src.ch[c].data = rt_mrg.data[c];
      end
      for (int l = 0; l < NLR; l++) begin
         rr_src.lr[l] = '0;
      end
   end

   dbf_pipe #(.W(RR_W), .D(BUS_PIPELINE)) u_pipe2 (
      .clk(clk),
      .rst(rst),
      .d(ul2_r),
      .q(rr_dly)
   );

   // Second area insertion per channel and per low-rate channel.
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         rr_mrg.ch[c] = ch_merge(rr_dly.ch[c], ul2_ins.ch[c],
            ul2_ins_en[c]);
      end
      for (int l = 0; l < NLR; l++) begin
         rr_mrg.lr[l] = ul2_lr_en[l] ? ul2_ins.lr[l] : rr_dly.lr[l];
      end
      out_nxt = rr_mrg;
   end

   // Header capture: only triggers not inhibited start a record.
   always_comb begin
      acc = trig_in && !out_r.ch[0].inhibit;
      hv_nxt = acc;
      hdr_nxt = acc ? out_r.ch[0].ts : hdr_r;
   end

   // Bus stages and header registers.
   always_ff @(posedge clk) begin
      if (rst) begin
         ul1_r <= '0;
         ul2_r <= '0;
         out_r <= '0;
         hdr_r <= '0;
         hv_r <= 1'b0;
      end else begin
         ul1_r <= rt_src;
         ul2_r <= rr_src;
         out_r <= out_nxt;
         hdr_r <= hdr_nxt;
         hv_r <= hv_nxt;
      end
   end

   assign reg_rd_data = rd_r;
   assign ul1_ext = ul1_r;
   assign ul2_ext = ul2_r;
   assign bus_out = out_r;
   assign hdr_ts = hdr_r;
   assign hdr_valid = hv_r;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   rr_copy_a: assert property (
      ul2_ext.ch[1].ts == ul2_ext.ch[0].ts
         && ul2_ext.ch[1].sync == ul2_ext.ch[0].sync)
      else $error("shared fields differ between channels");
   rr_conv_a: assert property (
      ##1 ul2_ext.ch[0].ts == $past(rt_mrg.ts)
         && ul2_ext.ch[1].data == $past(rt_mrg.data[1]))
      else $error("reduced bus not built from real-time bus");
   lr_empty_a: assert property (
      ##1 ul2_ext.lr == '0)
      else $error("low-rate channels not empty");
   hdr_cap_a: assert property (
      trig_in && !bus_out.ch[0].inhibit |=> hdr_valid
         && hdr_ts == $past(bus_out.ch[0].ts))
      else $error("header timestamp not captured");
   inh_block_a: assert property (
      trig_in && bus_out.ch[0].inhibit |=> !hdr_valid)
      else $error("inhibited trigger made a record");
   rt_sync_a: assert property (
      ##1 ul1_ext.sync == $past(waiting))
      else $error("sync field not driven from mechanism");
   hdr_c: cover property (trig_in && !bus_out.ch[0].inhibit);
   inh_c: cover property (trig_in && bus_out.ch[0].inhibit);
   ins_c: cover property (ul1_ins_en[INS_TS] ##1 ul2_lr_en[0]);
endmodule : dbf_top
`default_nettype wire

// file: bench/dbf_user_model.sv
// Behavioural model of the custom logic in both user areas.
// Assumes both buses arrive straight from the extraction registers.
`timescale 1ns/1ns
`default_nettype none
module dbf_user_model
   import dbf_pkg::*;
(
   input wire logic clk,
   input wire dbf_rt_s ul1_ext,
   input wire dbf_rr_s ul2_ext,
   output var dbf_rt_s ul1_ins,
   output var dbf_rr_s ul2_ins
);
   dbf_rt_s rt_nxt; // Processed real-time word before the delay.
   dbf_rr_s rr_nxt; // Processed reduced-rate word before the delay.
   dbf_rt_s rt_r [BUS_PIPELINE]; // Real-time latency stages.
   dbf_rr_s rr_r [BUS_PIPELINE]; // Reduced-rate latency stages.
   // Shared fields are taken whole, with no channel index; data inverts.
   always_comb begin
      rt_nxt = ul1_ext;
      rt_nxt.data = ~ul1_ext.data;
      rr_nxt = ul2_ext;
      for (int i = 0; i < NCH; i++) begin
         rr_nxt.ch[i].data = ~ul2_ext.ch[i].data;
      end
      // A slice sized from the low-rate count keeps the output rate low.
      for (int i = 0; i < NLR; i++) begin
         rr_nxt.lr[i].valid = 1'b1;
         rr_nxt.lr[i].data = dbf_lr_t'(ul2_ext.ch[i % NCH].data);
      end
   end
   // All fields of each bus share one delay line, so none slips against another.
   always_ff @(posedge clk) begin
      rt_r[0] <= rt_nxt;
      rr_r[0] <= rr_nxt;
      for (int k = 1; k < BUS_PIPELINE; k++) begin
         rt_r[k] <= rt_r[k-1];
         rr_r[k] <= rr_r[k-1];
      end
   end
   assign ul1_ins = rt_r[BUS_PIPELINE-1];
   assign ul2_ins = rr_r[BUS_PIPELINE-1];
endmodule : dbf_user_model
`default_nettype wire

// file: bench/test_data_bus_field_access.sv
// Self-checking bench for the data bus field access block.
// Assumes the user model answers with the pass-through depth.
`timescale 1ns/1ns
`default_nettype none
module test_data_bus_field_access import dbf_pkg::*; ;
   localparam int LAT = 2 * (BUS_PIPELINE + 1); // Extraction to output.
   logic clk, rst, reg_wr, reg_rd, sync_evt, trig_in, hdr_valid;
   logic [7:0] reg_addr;
   logic [31:0] reg_wr_data, reg_rd_data, rd_v;
   dbf_data_t [NCH-1:0] adc_data;
   dbf_data_t [NCH-1:0] hist [0:15]; // Past ADC words, newest first.
   dbf_rt_s ul1_ext, ul1_ins;
   dbf_rr_s ul2_ext, ul2_ins, bus_out;
   dbf_ins_t ul1_ins_en;
   dbf_ins_t [NCH-1:0] ul2_ins_en;
   logic [NLR-1:0] ul2_lr_en;
   logic [63:0] hdr_ts, prev_ts, hts, load_v;
   logic mon, chk_step, inh_exp, exp_hv; // Monitor switches and hopes.
   int fails, tests_run;
   dbf_top i_dbf_top (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rd_data(reg_rd_data), .adc_data(adc_data), .sync_evt(sync_evt),
      .trig_in(trig_in), .ul1_ext(ul1_ext), .ul1_ins(ul1_ins),
      .ul1_ins_en(ul1_ins_en), .ul2_ext(ul2_ext), .ul2_ins(ul2_ins),
      .ul2_ins_en(ul2_ins_en), .ul2_lr_en(ul2_lr_en), .bus_out(bus_out),
      .hdr_ts(hdr_ts), .hdr_valid(hdr_valid));
   dbf_user_model i_dbf_user_model (.clk(clk), .ul1_ext(ul1_ext),
      .ul2_ext(ul2_ext), .ul1_ins(ul1_ins), .ul2_ins(ul2_ins));
   // Compare one value with its expectation and count the outcome.
   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Print the verdict once and stop.
   task automatic print_verdict();
      if (fails == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict
   // One write cycle; the release waits a full edge so strobes never clash.
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wr_data <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : reg_write
   // One read cycle; data stands only in the cycle after the strobe.
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      // Sample off the edge, inside the one cycle where the data stand.
      #1;
      d = reg_rd_data;
   endtask : reg_read
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Random ADC words and record start requests every cycle.
   always @(posedge clk) begin : drive
      logic [NCH*PAR*SAMP_W-1:0] w;
      for (int k = 0; k < NCH * PAR * SAMP_W / 32; k++) w[k*32 +: 32] = $urandom;
      adc_data <= w;
      trig_in <= ($urandom % 4) == 0;
   end
   // Watches header, first-area extraction and bus output ports each edge while mon is set; expectations come from the history.
   always @(posedge clk) begin : watch
      logic [255:0] m;
      if (mon) begin
         check(hdr_valid, exp_hv);
         if (exp_hv) check(hdr_ts, hts);
         check(ul1_ext.inhibit, inh_exp);
         for (int i = 0; i < NCH; i++) begin
            check(ul1_ext.data[i], hist[0][i]);
            m = hist[LAT][i] ^ {256{ul1_ins_en[INS_DATA]}};
            check(bus_out.ch[i].data, m ^ {256{ul2_ins_en[i][INS_DATA]}});
            check(bus_out.ch[i].ts, ul1_ext.ts - 64'(LAT) * TS_STEP);
            check(bus_out.ch[i].inhibit, inh_exp);
            check(bus_out.ch[i].sync, ul1_ext.sync);
            check(bus_out.ch[i].valid, 1'b1);
            check(bus_out.lr[i].valid, ul2_lr_en[i]);
            check(bus_out.lr[i].data, ul2_lr_en[i] ? dbf_lr_t'(m) : '0);
         end
      end
      if (chk_step) check(ul1_ext.ts, prev_ts + TS_STEP);
      prev_ts = ul1_ext.ts;
      exp_hv = trig_in && !inh_exp;
      hts = bus_out.ch[0].ts;
      for (int k = 15; k > 0; k--) hist[k] <= hist[k-1];
      hist[0] <= adc_data;
   end
   // Bounded run; a hang counts as a mismatch.
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      print_verdict();
   end
   initial begin : main
      void'($urandom(32'h067a999d));
      {rst, reg_wr, reg_rd, sync_evt} = 4'h8;
      {mon, chk_step, inh_exp, exp_hv} = 4'h0;
      reg_addr = 8'h00;
      reg_wr_data = 32'h0;
      ul1_ins_en = '0;
      ul2_ins_en = '0;
      ul2_lr_en = '0;
      fails = 0;
      tests_run = 0;
      load_v = {$urandom, 25'($urandom), 7'h35}; // Odd phase shows load.
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      reg_read(ADR_STATUS, rd_v);
      check(rd_v, 32'h0);
      check(ul1_ext.sync, 1'b0);
      chk_step <= 1'b1;
      // Enable sets: all off, all on, then random; inhibit toggled midway.
      for (int p = 0; p < 12; p++) begin
         @(posedge clk);
         mon <= 1'b0;
         ul1_ins_en <= (p < 2) ? {5{p == 1}} : dbf_ins_t'($urandom);
         ul2_ins_en <= (p < 2) ? {(5*NCH){p == 1}} : (5*NCH)'($urandom);
         ul2_lr_en <= (p < 2) ? {NLR{p == 1}} : NLR'($urandom);
         if (p == 6 || p == 9) begin
            reg_write(ADR_CTRL, {31'h0, p == 6});
            inh_exp <= p == 6;
            reg_read(ADR_CTRL, rd_v);
            check(rd_v, {31'h0, p == 6});
         end
         repeat (LAT + 2) @(posedge clk);
         mon <= 1'b1;
         repeat (24) @(posedge clk);
      end
      // Arm, wait, then realign the time base with a sync event.
      mon <= 1'b0;
      chk_step <= 1'b0;
      reg_write(ADR_LOAD_LO, load_v[31:0]);
      reg_write(ADR_LOAD_HI, load_v[63:32]);
      reg_write(ADR_CTRL, 32'h2);
      reg_read(ADR_STATUS, rd_v);
      check(rd_v, 32'h1);
      check(ul1_ext.sync, 1'b1);
      sync_evt <= 1'b1;
      @(posedge clk);
      sync_evt <= 1'b0;
      repeat (3) @(posedge clk);
      check(ul1_ext.ts[6:0], load_v[6:0]);
      check(ul1_ext.ts - load_v < 64'h400, 1'b1);
      reg_read(ADR_STATUS, rd_v);
      check(rd_v, 32'h2);
      check(ul1_ext.sync, 1'b0);
      chk_step <= 1'b1;
      reg_read(ADR_CTRL, rd_v);
      check(rd_v, 32'h0);
      reg_read(8'h20, rd_v);
      check(rd_v, 32'h0);
      repeat (LAT) @(posedge clk);
      mon <= 1'b1;
      repeat (20) @(posedge clk);
      print_verdict();
   end
endmodule : test_data_bus_field_access
`default_nettype wire
